// ### design/dram_seq_consts.vh
// constants for the host dram access sequencer
`ifndef DRAM_SEQ_CONSTS_VH
`define DRAM_SEQ_CONSTS_VH
`define ST_IDLE 2'h0
`define ST_LEAD 2'h1
`define ST_CAS 2'h2
`define ST_GAP 2'h3
`define TT_READ_BIT 1
`define MEM_LIMIT_BIT 31
`define CYC_FIRST 5'h02
`define CYC_ROW_START 5'h03
`define CYC_RAS_LOW 5'h07
`define CYC_ACK_DRIVE 5'h04
`define CAS_HIT_START 5'h04
`define CAS_MISS_START 5'h0A
`define CAS_BASE_LEN 3'h3
`define READ_GAP 3'h1
`define WRITE_GAP 3'h2
`endif

// ### design/xfer_decode.v
// decodes a host transfer start into memory read or write
`include "dram_seq_consts.vh"
module xfer_decode (
    input wire [31:0] i_addr,
    input wire [4:0] i_transfer_type,
    input wire i_transfer_start_n,
    input wire i_burst_indicator_n,
    output wire o_mem_req,
    output wire o_is_write,
    output wire o_is_burst
);
    // memory space is 0 to 2G, direction from the type field
    assign o_mem_req = ~i_transfer_start_n & ~i_addr[`MEM_LIMIT_BIT];
    assign o_is_write = ~i_transfer_type[`TT_READ_BIT];
    assign o_is_burst = ~i_burst_indicator_n;
endmodule

// ### design/cas_timing.v
// column access timing for hit/miss, read/write, extension
`include "dram_seq_consts.vh"
module cas_timing (
    input wire i_hit,
    input wire i_write,
    input wire i_ext,
    output reg [4:0] o_start,
    output reg [2:0] o_len,
    output reg [2:0] o_adv_ph,
    output reg [2:0] o_gap
);
    // start cycle, cas low length, advance phase, cas high gap
    always @* begin
        if (i_hit) begin
            o_start = `CAS_HIT_START + {4'h0, i_write & i_ext};
        end else begin
            o_start = `CAS_MISS_START;
        end
        if (i_write) begin
            o_len = `CAS_BASE_LEN + {2'h0, ~i_hit & i_ext};
            o_adv_ph = o_len - 3'h1;
            o_gap = `WRITE_GAP;
        end else begin
            o_len = `CAS_BASE_LEN + {2'h0, i_ext};
            o_adv_ph = o_len - 3'h2;
            o_gap = `READ_GAP;
        end
    end
endmodule

// ### design/host_dram_access_sequencer.v
// host processor dram access sequencer, single and burst
`include "dram_seq_consts.vh"
module host_dram_access_sequencer #(
    parameter BURST_BEATS = 4
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_transfer_start_n,
    input wire [31:0] i_addr,
    input wire [4:0] i_transfer_type,
    input wire [2:0] i_transfer_size,
    input wire i_burst_indicator_n,
    input wire i_bus_grant_n,
    input wire i_row_match_n,
    input wire [7:0] i_cas_select,
    input wire i_cas_extend,
    input wire i_little_endian,
    output reg o_addr_sel_n,
    output reg o_host_data_sel_n,
    output reg o_mem_data_sel_n,
    output reg o_host_data_oe_n,
    output reg o_mem_data_oe_n,
    output reg o_we_n,
    output reg o_row_col_select,
    output reg o_ras_n,
    output reg [7:0] o_cas_n,
    output reg o_col_advance_n,
    output reg o_address_ack_n,
    output reg o_address_ack_oe,
    output reg o_transfer_ack_n,
    output reg o_transfer_ack_oe,
    output reg o_big_order_parity_en_n,
    output reg o_little_order_parity_en_n
);
    // beat index of the final beat, cut to the beat counter width
    localparam integer LAST_BEAT_I = BURST_BEATS - 1;
    localparam [1:0] LAST_BEAT = LAST_BEAT_I[1:0];

    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [4:0] cyc_r;
    reg [4:0] cyc_nxt;
    reg [2:0] ph_r;
    reg [2:0] ph_nxt;
    reg [1:0] beat_r;
    reg [1:0] beat_nxt;
    reg hit_r;
    reg hit_nxt;
    reg wr_r;
    reg burst_r;
    reg cas_ext_r;
    reg [7:0] cas_sel_r;
    reg in_xfer;
    reg lead_miss;
    reg rd_data;

    wire mem_req;
    wire is_write;
    wire is_burst;
    wire [4:0] cas_start;
    wire [2:0] cas_len;
    wire [2:0] adv_ph;
    wire [2:0] gap_len;
    wire last_beat;

    // transfer size is carried by the lane selects supplied alongside
    xfer_decode u_dec (
        .i_addr(i_addr),
        .i_transfer_type(i_transfer_type),
        .i_transfer_start_n(i_transfer_start_n),
        .i_burst_indicator_n(i_burst_indicator_n),
        .o_mem_req(mem_req),
        .o_is_write(is_write),
        .o_is_burst(is_burst)
    );

    cas_timing u_tim (
        .i_hit(hit_nxt),
        .i_write(wr_r),
        .i_ext(cas_ext_r),
        .o_start(cas_start),
        .o_len(cas_len),
        .o_adv_ph(adv_ph),
        .o_gap(gap_len)
    );

    assign last_beat = ~burst_r | (beat_r == LAST_BEAT);

    // sequence state: idle, lead-in, cas low, cas high gap
    always @* begin
        st_nxt = st_r;
        cyc_nxt = cyc_r;
        ph_nxt = ph_r;
        beat_nxt = beat_r;
        hit_nxt = hit_r;
        case (st_r)
            `ST_IDLE: begin
                beat_nxt = 2'h0;
                ph_nxt = 3'h0;
                if (mem_req) begin
                    st_nxt = `ST_LEAD;
                    cyc_nxt = `CYC_FIRST;
                end
            end
            `ST_LEAD: begin
                if (cyc_r == `CYC_FIRST) begin
                    hit_nxt = ~i_row_match_n;
                end
                cyc_nxt = cyc_r + 5'h01;
                if (cyc_nxt == cas_start) begin
                    st_nxt = `ST_CAS;
                    ph_nxt = 3'h0;
                end
            end
            `ST_CAS: begin
                cyc_nxt = cyc_r + 5'h01;
                if (ph_r == cas_len - 3'h1) begin
                    ph_nxt = 3'h0;
                    if (last_beat) begin
                        st_nxt = `ST_IDLE;
                    end else begin
                        st_nxt = `ST_GAP;
                        beat_nxt = beat_r + 2'h1;
                    end
                end else begin
                    ph_nxt = ph_r + 3'h1;
                end
            end
            default: begin
                cyc_nxt = cyc_r + 5'h01;
                if (ph_r == gap_len - 3'h1) begin
                    st_nxt = `ST_CAS;
                    ph_nxt = 3'h0;
                end else begin
                    ph_nxt = ph_r + 3'h1;
                end
            end
        endcase
    end

    // sequence registers; extension sampled only while idle
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_r <= `ST_IDLE;
            cyc_r <= 5'h00;
            ph_r <= 3'h0;
            beat_r <= 2'h0;
            hit_r <= 1'b0;
            wr_r <= 1'b0;
            burst_r <= 1'b0;
            cas_ext_r <= 1'b0;
            cas_sel_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cyc_r <= cyc_nxt;
            ph_r <= ph_nxt;
            beat_r <= beat_nxt;
            hit_r <= hit_nxt;
            if (st_r == `ST_IDLE) begin
                cas_ext_r <= i_cas_extend;
                if (mem_req) begin
                    wr_r <= is_write;
                    burst_r <= is_burst;
                    cas_sel_r <= i_cas_select;
                end
            end
        end
    end

    // qualifiers for the cycle about to start
    always @* begin
        in_xfer = (st_nxt != `ST_IDLE);
        lead_miss = (st_nxt == `ST_LEAD) & ~hit_nxt &
            (cyc_nxt >= `CYC_ROW_START);
        rd_data = ~wr_r & ((st_nxt == `ST_CAS) | (st_nxt == `ST_GAP));
    end

    // registered outputs, all computed for the next cycle
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_addr_sel_n <= 1'b1;
            o_host_data_sel_n <= 1'b1;
            o_mem_data_sel_n <= 1'b1;
            o_host_data_oe_n <= 1'b1;
            o_mem_data_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_row_col_select <= 1'b0;
            o_ras_n <= 1'b1;
            o_cas_n <= 8'hFF;
            o_col_advance_n <= 1'b1;
            o_address_ack_n <= 1'b1;
            o_address_ack_oe <= 1'b0;
            o_transfer_ack_n <= 1'b1;
            o_transfer_ack_oe <= 1'b0;
            o_big_order_parity_en_n <= 1'b1;
            o_little_order_parity_en_n <= 1'b1;
        end else begin
            // address path held for the whole transfer
            o_addr_sel_n <= ~in_xfer;
            // write path from cycle 2 until completion
            o_mem_data_oe_n <= ~(in_xfer & wr_st_nxt(st_r, wr_r,
                mem_req, is_write));
            o_we_n <= ~(in_xfer & wr_st_nxt(st_r, wr_r,
                mem_req, is_write));
            if (in_xfer) begin
                o_host_data_sel_n <= ~wr_st_nxt(st_r, wr_r,
                    mem_req, is_write);
            end else begin
                o_host_data_sel_n <= i_bus_grant_n |
                    i_transfer_type[`TT_READ_BIT];
            end
            // read data path from first cas to completion
            o_mem_data_sel_n <= ~rd_data;
            o_host_data_oe_n <= ~rd_data;
            o_big_order_parity_en_n <= ~(rd_data & ~i_little_endian);
            o_little_order_parity_en_n <= ~(rd_data & i_little_endian);
            // row access on a page miss
            o_row_col_select <= lead_miss &
                (cyc_nxt < `CYC_RAS_LOW + 5'h01);
            if (lead_miss & (cyc_nxt < `CYC_RAS_LOW)) begin
                o_ras_n <= 1'b1;
            end else if (lead_miss & (cyc_nxt == `CYC_RAS_LOW)) begin
                o_ras_n <= 1'b0;
            end
            // column strobes
            if (st_nxt == `ST_CAS) begin
                o_cas_n <= ~cas_sel_r;
            end else begin
                o_cas_n <= 8'hFF;
            end
            o_col_advance_n <= ~((st_nxt == `ST_CAS) & ~last_beat_nxt(
                burst_r, beat_nxt) & (ph_nxt == adv_ph));
            // acknowledges, tri-stated before cycle 4
            o_address_ack_oe <= in_xfer & ~((st_nxt == `ST_LEAD) &
                (cyc_nxt < `CYC_ACK_DRIVE));
            o_transfer_ack_oe <= in_xfer & ~((st_nxt == `ST_LEAD) &
                (cyc_nxt < `CYC_ACK_DRIVE));
            o_transfer_ack_n <= ~((st_nxt == `ST_CAS) &
                (ph_nxt == cas_len - 3'h1));
            o_address_ack_n <= ~((st_nxt == `ST_CAS) &
                (ph_nxt == cas_len - 3'h1) & (beat_nxt == 2'h0));
        end
    end

    // direction of the transfer in the next cycle
    function wr_st_nxt;
        input [1:0] st;
        input wr_lat;
        input req;
        input wr_in;
        begin
            if (st == `ST_IDLE) begin
                wr_st_nxt = req & wr_in;
            end else begin
                wr_st_nxt = wr_lat;
            end
        end
    endfunction

    // true when the given beat is the final one
    function last_beat_nxt;
        input brst;
        input [1:0] beat;
        begin
            last_beat_nxt = ~brst | (beat == LAST_BEAT);
        end
    endfunction
endmodule

// ### verif/dram_seq_asserts.sv
// port-level property checker for the dram access sequencer
module dram_seq_asserts #(
    parameter BURST_BEATS = 4
) (
    input wire i_sys_clk,
    input wire i_rst_n,
    input wire i_transfer_start_n,
    input wire [31:0] i_addr,
    input wire [4:0] i_transfer_type,
    input wire i_burst_indicator_n,
    input wire i_row_match_n,
    input wire i_cas_extend,
    input wire o_addr_sel_n,
    input wire o_host_data_sel_n,
    input wire o_mem_data_oe_n,
    input wire o_we_n,
    input wire o_row_col_select,
    input wire o_ras_n,
    input wire [7:0] o_cas_n,
    input wire o_col_advance_n,
    input wire o_address_ack_n,
    input wire o_address_ack_oe,
    input wire o_transfer_ack_n,
    input wire o_transfer_ack_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    reg busy_r, wr_r, hit_r, ext_r;
    reg [5:0] cyc_r;
    reg [2:0] left_r;
    wire take = !busy_r && !i_transfer_start_n && !i_addr[31];
    wire ack = busy_r && !o_transfer_ack_n && o_transfer_ack_oe;
    wire last = ack && left_r == 3'h1;
    wire cas_off = &o_cas_n;
    // cycle number of the visible outputs, as the host counts them
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            busy_r <= 1'b0;
            wr_r <= 1'b0;
            hit_r <= 1'b0;
            ext_r <= 1'b0;
            cyc_r <= 6'h00;
            left_r <= 3'h0;
        end else begin
            cyc_r <= take ? 6'h02 : cyc_r + 6'h01;
            if (cyc_r == 6'h02)
                hit_r <= !i_row_match_n;
            if (take) begin
                busy_r <= 1'b1;
                wr_r <= !i_transfer_type[1];
                ext_r <= i_cas_extend;
                left_r <= i_burst_indicator_n ? 3'h1 : 3'(BURST_BEATS);
            end else if (ack) begin
                busy_r <= !last;
                left_r <= left_r - 3'h1;
            end
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    a_ack_not_early: assert property (
        busy_r && cyc_r < 6'h04 |-> !o_transfer_ack_oe && !o_address_ack_oe)
        else $error("ack driven early");
    a_write_paths: assert property (
        busy_r && wr_r && cyc_r == 6'h02 |-> !o_addr_sel_n
        && !o_host_data_sel_n && !o_mem_data_oe_n && !o_we_n)
        else $error("write paths late");
    a_write_cas_hit: assert property (
        busy_r && wr_r && hit_r && cyc_r == (ext_r ? 6'h04 : 6'h03)
        |-> cas_off ##1 !cas_off) else $error("write cas start");
    a_hit_ack_time: assert property (
        busy_r && hit_r && cyc_r == (ext_r ? 6'h07 : 6'h06)
        |-> !o_transfer_ack_n && !o_address_ack_n) else $error("hit ack");
    a_miss_ack_time: assert property (
        busy_r && !hit_r && cyc_r == (ext_r ? 6'h0D : 6'h0C)
        |-> !o_transfer_ack_n && !o_address_ack_n) else $error("miss ack");
    a_miss_row_seq: assert property (
        busy_r && !hit_r && cyc_r == 6'h03 |-> (o_row_col_select
        && o_ras_n) [*4] ##1 !o_ras_n ##1 !o_row_col_select)
        else $error("row sequence");
    a_adv_one_cycle: assert property (
        $fell(o_col_advance_n) |=> o_col_advance_n) else $error("advance");
    a_write_adv_ack: assert property (
        busy_r && wr_r && !o_col_advance_n |-> !o_transfer_ack_n)
        else $error("advance without ack");
    a_read_cas_gap: assert property (
        ack && !wr_r && !last |=> cas_off ##1 !cas_off)
        else $error("read gap");
    a_write_cas_gap: assert property (
        ack && wr_r && !last |=> cas_off [*2] ##1 !cas_off)
        else $error("write gap");
    a_end_negate: assert property (
        last |=> o_addr_sel_n && o_we_n && cas_off && !o_transfer_ack_oe)
        else $error("controls held");
    c_write_done: cover property (last && wr_r);
    c_miss_ext: cover property (ack && ext_r && !hit_r);
    c_burst_adv: cover property (busy_r && !o_col_advance_n);
endmodule
bind host_dram_access_sequencer dram_seq_asserts #(
    .BURST_BEATS(BURST_BEATS)
) dram_seq_asserts_i (.*);

// ### verif/host_master_model.sv
// host bus master model issuing single and burst transfers
module host_master_model (
    input wire i_sys_clk,
    input wire i_address_ack_n,
    input wire i_address_ack_oe,
    output logic o_transfer_start_n,
    output logic [31:0] o_addr,
    output logic [4:0] o_transfer_type,
    output logic o_burst_indicator_n,
    output logic o_row_match_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_transfer_start_n = 1'b1;
        o_addr = 32'hFFFF_FFFF;
        o_transfer_type = 5'h00;
        o_burst_indicator_n = 1'b1;
        o_row_match_n = 1'b1;
    end
    // whole address group presented with the start pulse
    task automatic issue(input logic [31:0] a, input bit wr, bst, hit);
        @(negedge i_sys_clk);
        o_transfer_start_n = 1'b0;
        o_addr = a;
        o_transfer_type = {3'h0, !wr, 1'b0};
        o_burst_indicator_n = !bst;
        o_row_match_n = !hit;
        @(negedge i_sys_clk);
        o_transfer_start_n = 1'b1;
    endtask
    // address released once acknowledged, so show a changed value
    always @(negedge i_sys_clk)
        if (!i_address_ack_n && i_address_ack_oe)
            o_addr <= ~o_addr;
endmodule

// ### verif/host_dram_access_sequencer_tb.sv
// self-checking bench for the host dram access sequencer
module host_dram_access_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] i_cas_select = 8'h0F;
    logic i_cas_extend = 1'b0;
    logic i_little_endian = 1'b0;
    wire i_transfer_start_n, i_burst_indicator_n, i_row_match_n;
    wire [31:0] i_addr;
    wire [4:0] i_transfer_type;
    wire [2:0] i_transfer_size = 3'h3;
    wire i_bus_grant_n = 1'b0;
    wire o_addr_sel_n, o_host_data_sel_n, o_mem_data_sel_n, o_we_n;
    wire o_host_data_oe_n, o_mem_data_oe_n, o_row_col_select, o_ras_n;
    wire o_col_advance_n, o_address_ack_n, o_address_ack_oe;
    wire o_transfer_ack_n, o_transfer_ack_oe;
    wire o_big_order_parity_en_n, o_little_order_parity_en_n;
    wire [7:0] o_cas_n;
    integer seed = 61105;
    integer err_total = 0;
    integer tests_run = 0;
    always #12.5 i_sys_clk = ~i_sys_clk;
    host_dram_access_sequencer host_dram_access_sequencer_i (.*);
    host_master_model host_master_model_i (
        .i_sys_clk(i_sys_clk),
        .i_address_ack_n(o_address_ack_n),
        .i_address_ack_oe(o_address_ack_oe),
        .o_transfer_start_n(i_transfer_start_n),
        .o_addr(i_addr),
        .o_transfer_type(i_transfer_type),
        .o_burst_indicator_n(i_burst_indicator_n),
        .o_row_match_n(i_row_match_n)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one transfer against a cycle model of the ack schedule
    task automatic run_one(input bit wr, bst, hit, hi);
        int exp_q[$];
        int ack_q[$];
        int adv = 0;
        int address_ack_n = 0;
        int lim;
        if (!hi) begin
            exp_q.push_back((hit ? 6 : 12) + i_cas_extend);
            for (int k = 1; bst && k < 4; k++)
                exp_q.push_back(exp_q[0] + k * (wr ?
                    5 + (i_cas_extend && !hit) : 4 + i_cas_extend));
        end
        lim = exp_q.size() ? exp_q[$] + 3 : 30;
        host_master_model_i.issue({hi, 31'($random(seed))}, wr, bst, hit);
        for (int c = 2; c <= lim; c++) begin
            if (c == 2)
                check({o_addr_sel_n, o_we_n}, {hi, !(wr && !hi)});
            if (c < 4)
                check(o_transfer_ack_oe, 1'b0);
            if (o_transfer_ack_n === 1'b0 && o_transfer_ack_oe) begin
                ack_q.push_back(c);
                check(o_cas_n, {24'h0, ~i_cas_select});
                if (!wr)
                    check({o_mem_data_sel_n, o_host_data_oe_n,
                        o_big_order_parity_en_n, o_little_order_parity_en_n},
                        {2'b00, i_little_endian, !i_little_endian});
            end
            adv += (o_col_advance_n === 1'b0);
            address_ack_n += (o_address_ack_n === 1'b0 && o_address_ack_oe === 1'b1);
            @(negedge i_sys_clk);
        end
        check(ack_q.size(), exp_q.size());
        foreach (exp_q[i])
            check(ack_q[i], exp_q[i]);
        check(adv, (bst && !hi) ? 3 : 0);
        check(address_ack_n, !hi);
    endtask
    // 16 counted mode patterns first (bursts on misses only, no upper address), then random mixes
    initial begin
        bit [4:0] r;
        repeat (3) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        for (int n = 0; n < 48; n++) begin
            r = (n < 16) ? n[4:0] : 5'($random(seed));
            i_cas_extend = r[3];
            i_little_endian = 1'($random(seed));
            i_cas_select = 8'($random(seed)) | 8'h01;
            run_one(r[0], r[1] && !r[2], r[2], r[4] && r[0]);
        end
        final_report();
    end
    // hang guard
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule
